//--- hdl/fcm_pkg.sv
// Package with the constants and types of the fuse check mode control.
package fcm_pkg;
	localparam int FCM_SYNC_STAGES = 2;
	localparam logic [1:0] FCM_RISE_RESET = 2'h0;
	localparam logic [1:0] FCM_RISES_TO_END = 2'h2;
	localparam int FCM_KEY_BITS = 256;
	localparam logic FCM_TMS_IDLE = 1'h1;
	localparam logic FCM_TEST_IDLE = 1'h0;
	localparam logic FCM_FUSE_IDLE = 1'h0;
	localparam logic [2:0] FCM_STATUS_RESET = 3'h0;

	typedef enum logic [1:0] {
		FCM_ARMED,
		FCM_ACTIVE,
		FCM_DONE
	} fcm_state_t;

	typedef struct packed {
		logic active;
		logic sense_en;
		logic done;
	} fcm_status_t;
endpackage : fcm_pkg

//--- hdl/fcm_fuse_check.sv
// Fuse check mode controller watching TMS and TEST on the test-port clock.
`timescale 1ns/1ps
`default_nettype none
module fcm_fuse_check
	import fcm_pkg::*;
#(
	parameter int SYNC_STAGES = FCM_SYNC_STAGES,
	parameter logic [1:0] RISES_TO_END = FCM_RISES_TO_END
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic test_pin,
	input wire logic fuse_present,
	output var fcm_status_t status,
	output logic fuse_sense_en
);

	// Elaboration checks on the parameters.

	if (SYNC_STAGES < 2) begin : g_bad_stages
		$error("SYNC_STAGES must be at least two");
	end

	if (RISES_TO_END == 2'h0) begin : g_bad_rises
		$error("RISES_TO_END must not be zero");
	end

	// State decoding used by the output group.

	function automatic logic is_active(input fcm_state_t s);
		return s == FCM_ACTIVE;
	endfunction : is_active

	function automatic logic is_done(input fcm_state_t s);
		return s == FCM_DONE;
	endfunction : is_done

	// Pins seen by the link logic, in the order fuse, test, tms.

	localparam int N_PINS = 3;
	localparam logic [N_PINS-1:0] PIN_IDLE = {FCM_FUSE_IDLE,
		FCM_TEST_IDLE, FCM_TMS_IDLE};

	logic [N_PINS-1:0] pin_raw;
	logic [N_PINS-1:0] pin_s;

	logic tms_s;
	logic test_s;
	logic fuse_s;

	logic tms_prev_reg;
	logic tms_prev_next;
	logic tms_rise;

	fcm_state_t state_reg;
	fcm_state_t state_next;

	logic [1:0] rises_reg;
	logic [1:0] rises_next;
	logic [1:0] rise_count;

	logic sense_reg;
	logic sense_next;
	logic active_reg;
	logic active_next;
	logic done_reg;
	logic done_next;

	logic [2:0] st_link;
	logic [2:0] st_meta_reg;
	logic [2:0] st_meta_next;
	logic [2:0] st_sync_reg;
	logic [2:0] st_sync_next;

	assign pin_raw = {fuse_present, test_pin, tms};

	// Every pin passes a chain of flops on tck before any logic reads it.

	genvar gi;
	generate
		for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_sync
			logic [SYNC_STAGES-1:0] sync_reg;
			logic [SYNC_STAGES-1:0] sync_next;

			always_comb begin
				sync_next = {sync_reg[SYNC_STAGES-2:0], pin_raw[gi]};
			end

			always_ff @(posedge tck or posedge rst) begin
				if (rst) begin
					sync_reg <= {SYNC_STAGES{PIN_IDLE[gi]}};
				end else begin
					sync_reg <= sync_next;
				end
			end

			assign pin_s[gi] = sync_reg[SYNC_STAGES-1];
		end
	endgenerate

	assign tms_s = pin_s[0];
	assign test_s = pin_s[1];
	// The strap is only read here; protection rests on the blown fuse.
	assign fuse_s = pin_s[2];

	// Edge group: remembers the last synchronised TMS level.

	always_comb begin
		tms_prev_next = tms_s;
	end

	// The idle high reset value means a pin held low through power-up
	// looks like a falling edge on the first samples, which is intended.
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			tms_prev_reg <= FCM_TMS_IDLE;
		end else begin
			tms_prev_reg <= tms_prev_next;
		end
	end

	assign tms_rise = tms_s && !tms_prev_reg;

	// Mode group: armed, active and done.

	always_comb begin
		state_next = state_reg;
		rises_next = rises_reg;
		rise_count = rises_reg + 2'h1;
		case (state_reg)
			FCM_ARMED: begin
				if (fuse_s && test_s && !tms_s && tms_prev_reg) begin
					state_next = FCM_ACTIVE;
					rises_next = FCM_RISE_RESET;
				end
			end
			FCM_ACTIVE: begin
				if (!test_s) begin
					state_next = FCM_DONE;
				end else if (tms_rise) begin
					// The falling edge that started the mode counts the
					// following rise as the first.
					rises_next = rise_count;
					if (rise_count == RISES_TO_END) begin
						state_next = FCM_DONE;
					end
				end
			end
			FCM_DONE: begin
				state_next = FCM_DONE;
			end
			default: begin
				state_next = FCM_DONE;
			end
		endcase
	end

	// Only the power-on reset leaves DONE.
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			state_reg <= FCM_ARMED;
			rises_reg <= FCM_RISE_RESET;
		end else begin
			state_reg <= state_next;
			rises_reg <= rises_next;
		end
	end

	// Output group: the sense enable is a flop, so it cannot glitch
	// while the state and the synchronised pins settle.

	always_comb begin
		sense_next = is_active(state_next) && !tms_s && test_s;
		active_next = is_active(state_next);
		done_next = is_done(state_next);
	end

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			sense_reg <= 1'b0;
			active_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			sense_reg <= sense_next;
			active_reg <= active_next;
			done_reg <= done_next;
		end
	end

	assign fuse_sense_en = sense_reg;

	// Status group: each bit is a steady level from a link flop and
	// crosses by two flops. The bits may land one clock apart, which
	// is harmless for status that software only polls.

	assign st_link = {active_reg, sense_reg, done_reg};

	always_comb begin
		st_meta_next = st_link;
		st_sync_next = st_meta_reg;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_meta_reg <= FCM_STATUS_RESET;
			st_sync_reg <= FCM_STATUS_RESET;
		end else begin
			st_meta_reg <= st_meta_next;
			st_sync_reg <= st_sync_next;
		end
	end

	assign status = fcm_status_t'(st_sync_reg);

endmodule : fcm_fuse_check
`default_nettype wire

//--- verif/fcm_fuse_check_asserts.sv
// Port assertions for the fuse check mode control.
`timescale 1ns/1ps
`default_nettype none
module fcm_fuse_check_asserts import fcm_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic test_pin,
	input wire logic fuse_present,
	input wire fcm_status_t status,
	input wire logic fuse_sense_en
);
	default clocking @(posedge tck); endclocking
	default disable iff (rst);
	sequence fall_s; $fell(tms) && test_pin && fuse_present; endsequence
	sequence low_s; (!tms && test_pin)[*2]; endsequence
	tms_low_a: assert property (fuse_sense_en |-> !$past(tms, 3))
		else $error("sense tms");
	test_high_a: assert property (fuse_sense_en |-> $past(test_pin, 3))
		else $error("sense test");
	fuse_need_a: assert property (fuse_sense_en |-> fuse_present)
		else $error("no fuse");
	activate_a: assert property (fall_s ##0 !status.done ##1 low_s |=>
		fuse_sense_en) else $error("no start");
	test_end_a: assert property ($fell(test_pin) && fuse_sense_en |->
		##[2:6] status.done) else $error("no end");
	done_quiet_a: assert property (status.done |-> !fuse_sense_en)
		else $error("sense in done");
	done_hold_a: assert property (status.done |=> status.done)
		else $error("done lost");
	rearm_a: assert property ($fell(rst) |-> status == 3'h0)
		else $error("not rearmed");
endmodule : fcm_fuse_check_asserts
`default_nettype wire

//--- verif/fcm_prog.sv
// Programmer model driving the test clock, TMS and TEST.
`timescale 1ns/1ps
`default_nettype none
module fcm_prog (
	output var logic tck,
	output var logic tms,
	output var logic test_pin
);
	logic run = 1'h0;
	initial {tck, tms, test_pin} = 3'h3;
	// The test clock stands still between sessions.
	always #40 tck = run & ~tck;
	task automatic go(input logic t, s, input int n);
		run = 1'h1;
		@(posedge tck) {tms, test_pin} <= {t, s};
		repeat (n) @(posedge tck);
		#1 run = 1'h0;
	endtask : go
endmodule : fcm_prog
`default_nettype wire

//--- verif/fcm_fuse_check_tb.sv
// Self-checking bench for the fuse check mode control.
`timescale 1ns/1ps
`default_nettype none
module fcm_fuse_check_tb;
	logic clock = 1'h0, rst = 1'h1, fuse = 1'h1;
	wire tck, tms, tst, sen;
	fcm_pkg::fcm_status_t st;
	int n_mismatch = 0, checked = 0;
	initial forever #12.5 clock = ~clock;
	fcm_prog fcm_prog_inst (.tck(tck), .tms(tms), .test_pin(tst));
	fcm_fuse_check fcm_fuse_check_inst (.clock(clock), .rst(rst), .tck(tck),
		.tms(tms), .test_pin(tst), .fuse_present(fuse), .status(st),
		.fuse_sense_en(sen));
	task automatic chk(input logic got, exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic por(input logic t, f);
		@(posedge clock) {rst, fuse} <= {1'h1, f};
		fcm_prog_inst.go(t, 1'h1, 2);
		repeat (6) @(posedge clock);
		rst <= 1'h0;
	endtask : por
	task automatic t_edges;
		por(1'h1, 1'h1);
		for (int i = 0; i < 5; i++) begin
			fcm_prog_inst.go(i[0], 1'h1, 4);
			chk(sen, 1'(5'h05 >> i));
		end
		chk(st.done, 1'h1);
		$display("edges test end");
	endtask : t_edges
	task automatic t_held;
		por(1'h0, 1'h1);
		fcm_prog_inst.go(1'h0, 1'h1, 4);
		chk(sen, 1'h1);
		chk(st.active & st.sense_en, 1'h1);
		fcm_prog_inst.go(1'h0, 1'h0, 4);
		repeat (3) @(posedge clock);
		chk(sen | ~st.done, 1'h0);
		chk(st.active | st.sense_en, 1'h0);
		$display("held test end");
	endtask : t_held
	task automatic t_nofuse;
		por(1'h1, 1'h0);
		fcm_prog_inst.go(1'h0, 1'h1, 4);
		chk(sen, 1'h0);
		$display("no fuse test end");
	endtask : t_nofuse
	task automatic wrap_up;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#100000 n_mismatch++;
		wrap_up();
	end
	initial begin
		t_edges();
		t_held();
		t_nofuse();
		wrap_up();
	end
endmodule : fcm_fuse_check_tb
bind fcm_fuse_check fcm_fuse_check_asserts fcm_fuse_check_asserts_inst (.*);
`default_nettype wire
